/* File: verilog/smspi_defines.vh */
`ifndef SMSPI_DEFINES_VH
`define SMSPI_DEFINES_VH
// Bit counter width and last bit index of a byte
`define SMSPI_BIT_W 3
`define SMSPI_BYTE_LAST 3'h7
// Reset values of the volatile status flags
`define SMSPI_WLATCH_RST 1'b0
`define SMSPI_BUSY_RST 1'b0
`endif

/* File: verilog/smspi_sync.v */
`timescale 1ns/1ps
module smspi_sync (
    // Clock and reset
    input wire clk,
    input wire arst_n,
    // Asynchronous level in, synchronised level out
    input wire din,
    output reg dout
);
reg meta_q;
always @(posedge clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        meta_q <= 1'b0;
        dout <= 1'b0;
    end
    else
    begin
        meta_q <= din;
        dout <= meta_q;
    end
end
endmodule

/* File: verilog/smspi_core.v */
`timescale 1ns/1ps
`include "smspi_defines.vh"
module smspi_core (
    // Clock and power-on reset
    input wire clk,
    input wire arst_n,
    // Serial pins (asynchronous)
    input wire sclk,
    input wire sel_n,
    input wire sdi,
    input wire pause_n,
    input wire wprot_n,
    // Serial output as two signals; enable is active low
    output reg sdo_o,
    output reg sdo_oe_n,
    // Byte stream toward the instruction logic
    output reg [7:0] rx_byte,
    output reg rx_valid,
    output reg cmd_end,
    output reg cmd_aligned,
    output reg wprot_sync,
    // Read data from the instruction logic
    input wire [7:0] tx_byte,
    input wire tx_enable,
    output reg tx_take,
    // Status flags kept here, set and cleared by the instruction logic
    input wire wlatch_set,
    input wire wlatch_clr,
    input wire busy_set,
    input wire busy_clr,
    output reg write_latch_flag,
    output reg busy_flag,
    // Power state
    output reg active,
    output reg selected
);
wire sclk_s;
wire sel_n_s;
wire sdi_s;
wire pause_n_s;
wire wprot_s;
reg sclk_q;
reg sel_n_q;
reg pause_n_q;
reg armed_q;
reg paused_q;
reg [`SMSPI_BIT_W-1:0] bit_q;
reg [7:0] sh_q;
reg [7:0] tx_q;
reg got_bit_q;
wire rise;
wire fall;
wire sel_fall;
wire sel_rise;

function [`SMSPI_BIT_W-1:0] smspi_inc;
    input [`SMSPI_BIT_W-1:0] v;
    begin
        smspi_inc = v + 3'h1;
    end
endfunction

function smspi_edge;
    input now_v;
    input was_v;
    begin
        smspi_edge = now_v & ~was_v;
    end
endfunction

function smspi_boundary;
    input [`SMSPI_BIT_W-1:0] bits;
    input seen;
    begin
        smspi_boundary = seen && (bits == 3'h0);
    end
endfunction

smspi_sync u_sclk (.clk(clk), .arst_n(arst_n), .din(sclk), .dout(sclk_s));
smspi_sync u_sel (.clk(clk), .arst_n(arst_n), .din(sel_n), .dout(sel_n_s));
smspi_sync u_sdi (.clk(clk), .arst_n(arst_n), .din(sdi), .dout(sdi_s));
smspi_sync u_pause (.clk(clk), .arst_n(arst_n), .din(pause_n), .dout(pause_n_s));
smspi_sync u_wp (.clk(clk), .arst_n(arst_n), .din(wprot_n), .dout(wprot_s));

// Edges of the sampled clock; polarity of idle level is irrelevant
assign rise = smspi_edge(sclk_s, sclk_q);
assign fall = smspi_edge(sclk_q, sclk_s);
assign sel_fall = smspi_edge(sel_n_q, sel_n_s);
assign sel_rise = smspi_edge(sel_n_s, sel_n_q);

// Select history resets low like its synchroniser, so a select held low out
// of reset never shows a falling edge; it must be seen high first.
always @(posedge clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        sclk_q <= 1'b0;
        sel_n_q <= 1'b0;
        pause_n_q <= 1'b1;
        armed_q <= 1'b0;
        paused_q <= 1'b0;
        bit_q <= 3'h0;
        sh_q <= 8'h00;
        tx_q <= 8'h00;
        got_bit_q <= 1'b0;
        sdo_o <= 1'b0;
        sdo_oe_n <= 1'b1;
        rx_byte <= 8'h00;
        rx_valid <= 1'b0;
        cmd_end <= 1'b0;
        cmd_aligned <= 1'b0;
        wprot_sync <= 1'b1;
        tx_take <= 1'b0;
        active <= 1'b0;
        selected <= 1'b0;
    end
    else
    begin
        sclk_q <= sclk_s;
        sel_n_q <= sel_n_s;
        pause_n_q <= pause_n_s;
        rx_valid <= 1'b0;
        cmd_end <= 1'b0;
        tx_take <= 1'b0;
        wprot_sync <= wprot_s;
        active <= armed_q & ~sel_n_s;
        if (sel_n_s)
        begin
            // Deselect ends the frame, also from pause, and clears the bit count
            armed_q <= 1'b0;
            paused_q <= 1'b0;
            selected <= 1'b0;
            sdo_oe_n <= 1'b1;
            bit_q <= 3'h0;
            got_bit_q <= 1'b0;
            if (sel_rise && armed_q && !paused_q)
            begin
                // Ends the command on a deselect of an armed frame outside pause; cmd_aligned marks a whole byte boundary after the last bit
                cmd_end <= 1'b1;
                cmd_aligned <= smspi_boundary(bit_q, got_bit_q);
            end
        end
        else
        begin
            if (sel_fall)
            begin
                armed_q <= 1'b1;
                selected <= 1'b1;
                bit_q <= 3'h0;
            end
            // Pause changes only count while the clock is low
            if (armed_q && !sclk_s && pause_n_q && !pause_n_s)
                paused_q <= 1'b1;
            else if (paused_q && !sclk_s && !pause_n_q && pause_n_s)
                paused_q <= 1'b0;
            if (paused_q)
                sdo_oe_n <= 1'b1;
            else if (armed_q && rise)
            begin
                sh_q <= {sh_q[6:0], sdi_s};
                bit_q <= smspi_inc(bit_q);
                got_bit_q <= 1'b1;
                if (bit_q == `SMSPI_BYTE_LAST)
                begin
                    rx_byte <= {sh_q[6:0], sdi_s};
                    rx_valid <= 1'b1;
                end
            end
            // No output before the first bit: with idle-high clock the first edge is a fall
            else if (armed_q && fall && tx_enable && got_bit_q)
            begin
                // Output bit changes on the falling edge, MSB first
                sdo_oe_n <= 1'b0;
                if (smspi_boundary(bit_q, got_bit_q))
                begin
                    sdo_o <= tx_byte[7];
                    tx_q <= {tx_byte[6:0], 1'b0};
                    tx_take <= 1'b1;
                end
                else
                begin
                    sdo_o <= tx_q[7];
                    tx_q <= {tx_q[6:0], 1'b0};
                end
            end
        end
    end
end

// Flags sit apart from the frame logic: a deselect in pause must not touch them
always @(posedge clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        write_latch_flag <= `SMSPI_WLATCH_RST;
        busy_flag <= `SMSPI_BUSY_RST;
    end
    else
    begin
        // Set wins over clear
        write_latch_flag <= wlatch_set | (write_latch_flag & ~wlatch_clr);
        busy_flag <= busy_set | (busy_flag & ~busy_clr);
    end
end
endmodule

/* File: dv/smspi_core_monitor.sv */
`timescale 1ns/1ps
module smspi_core_monitor (
    input wire clk, arst_n, sel_n, busy_set, wlatch_set,
    input wire [7:0] tx_byte,
    input wire sdo_o, sdo_oe_n, rx_valid, cmd_end, cmd_aligned, tx_take,
    input wire write_latch_flag, busy_flag, selected);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_oe_idle: assert property (!selected |=> sdo_oe_n) else $error("q on");
    a_sel_edge: assert property ($rose(selected) |-> $past(!sel_n)) else $error("sel");
    a_rst_clear: assert property ($rose(arst_n) |-> !busy_flag) else $error("rst");
    a_take_msb: assert property (tx_take |-> sdo_o == $past(tx_byte[7])) else $error("msb");
    a_rx_pulse: assert property (rx_valid |=> !rx_valid) else $error("rx");
    a_busy_set: assert property (busy_set |=> busy_flag) else $error("busy");
    a_wl_cause: assert property ($rose(write_latch_flag) |-> $past(wlatch_set))
        else $error("wl");
    a_end_once: assert property (cmd_end |-> $past(sel_n) ##1 !cmd_end) else $error("end");
    cover property (rx_valid);
    cover property (tx_take);
    cover property (cmd_end && cmd_aligned);
endmodule
bind smspi_core smspi_core_monitor smspi_core_monitor_i (.*);

/* File: dv/smspi_master.sv */
`timescale 1ns/1ps
module smspi_master (
    input wire clk, go, cpol, q,
    input wire [15:0] tx,
    output reg done = 1'h0, sclk = 1'h0, sel_n = 1'h0, sdi = 1'h0,
    output reg [15:0] rx = 16'h0);
    // Sample the read line just before the next fall takes effect
    always @(posedge clk)
    begin
        {done, sclk} <= {1'h0, cpol};
        if (go)
        begin
            sel_n <= 1'h1;
            repeat (4) @(posedge clk);
            sel_n <= 1'h0;
            repeat (4) @(posedge clk);
            for (int i = 15; i >= 0; i--)
            begin
                {sclk, sdi, rx} <= {1'h0, tx[i], rx[14:0], q};
                repeat (4) @(posedge clk);
                sclk <= 1'h1;
                repeat (4) @(posedge clk);
            end
            {sclk, rx} <= {cpol, rx[14:0], q};
            repeat (4) @(posedge clk);
            {sel_n, done} <= 2'h3;
        end
    end
endmodule

/* File: dv/serial_memory_spi_front_end_tb.sv */
`timescale 1ns/1ps
module serial_memory_spi_front_end_tb;
    reg clk = 1'h0, arst_n = 1'h0, go = 1'h0, cpol = 1'h0, wprot_n = 1'h1, pause_n = 1'h1;
    reg tx_enable = 1'h1, wlatch_set = 1'h0, wlatch_clr = 1'h0, busy_set = 1'h0, busy_clr = 1'h0;
    reg pz = 1'h0;
    reg [15:0] tx = 16'h0, lfsr = 16'h19;
    reg [7:0] tx_byte = 8'h0, qr[$];
    integer err_count = 0, n_tests = 0;
    wire sclk, sel_n, sdi, done, sdo_o, sdo_oe_n, rx_valid, cmd_end, cmd_aligned, tx_take, q;
    wire wprot_sync, write_latch_flag, busy_flag, active, selected;
    wire [7:0] rx_byte;
    wire [15:0] rx;
    assign q = sdo_oe_n ? ~sdo_o : sdo_o;
    smspi_core smspi_core_i (.*);
    smspi_master smspi_master_i (.*);
    function [15:0] nxt(input [15:0] s);
        nxt = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task check(input [15:0] seen, input [15:0] exp, input string what);
        n_tests++;
        if (seen !== exp)
            $display("mismatch %s exp %h seen %h", what, exp, seen);
        err_count += (seen !== exp);
    endtask
    task print_verdict(input integer extra);
        err_count += extra;
        $display("tests %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial forever #50 clk = ~clk;
    initial #3000000 print_verdict(1);
    always @(posedge clk)
    begin
        lfsr <= nxt(lfsr);
        {wlatch_set, wlatch_clr, busy_set, busy_clr} <= lfsr[3:0];
        if ((rx_valid || done) && !pz)
            check(done ? rx[7:0] : rx_byte, qr.pop_front(), "data");
        if (done && !pz)
        begin
            check(active, 1'h1, "active");
            check(wprot_sync, wprot_n, "wprot");
        end
        if (pz)
        begin
            check(sdo_oe_n, 1'h1, "hiz");
            check(rx_valid | cmd_end, 1'h0, "paused");
        end
        if (cmd_end)
            check(cmd_aligned, 1'h1, "aligned");
    end
    initial
    begin
        repeat (16) @(posedge clk);
        arst_n <= 1'h1;
        repeat (12) @(posedge clk);
        check(selected, 1'h0, "selected");
        for (int k = 0; k < 9; k++)
        begin
            {wprot_n, cpol} <= k[1:0];
            tx <= lfsr;
            tx_byte <= lfsr[11:4];
            go <= 1'h1;
            @(posedge clk);
            go <= 1'h0;
            if (k == 4)
            begin
                @(negedge sel_n);
                @(negedge sclk);
                @(posedge clk);
                pause_n <= 1'h0;
                repeat (4) @(posedge clk);
                pz <= 1'h1;
                @(posedge done);
                repeat (6) @(posedge clk);
                {pz, pause_n} <= 2'h1;
            end
            else
            begin
                qr = {qr, tx[15:8], tx[7:0], tx_byte};
                @(posedge done);
            end
            repeat (5) @(posedge clk);
            check(selected | active, 1'h0, "deselect");
            check(sdo_oe_n, 1'h1, "released");
        end
        print_verdict(0);
    end
endmodule
